//--- verilog/twowire_pkg.sv
`default_nettype none
package twowire_pkg;
    // register indices on the plain register port
    localparam logic [1:0] ctrl_off   = 2'h0;
    localparam logic [1:0] status_off = 2'h1;
    localparam logic [1:0] data_off   = 2'h2;
    localparam logic [1:0] addr_off   = 2'h3;
    // serial_control_reg bit positions
    localparam int flag_pos   = 7;
    localparam int ack_en_pos = 6;
    localparam int start_pos  = 5;
    localparam int enable_pos = 2;
    // slave_address_reg general call enable position
    localparam int gce_pos    = 0;
    // status codes, prescaler bits always zero
    localparam logic [7:0] st_own_w    = 8'h60;
    localparam logic [7:0] st_arb_own  = 8'h68;
    localparam logic [7:0] st_gc       = 8'h70;
    localparam logic [7:0] st_arb_gc   = 8'h78;
    localparam logic [7:0] st_own_data = 8'h80;
    localparam logic [7:0] st_own_nack = 8'h88;
    localparam logic [7:0] st_gc_data  = 8'h90;
    localparam logic [7:0] st_gc_nack  = 8'h98;
    localparam logic [7:0] st_stop     = 8'ha0;
    localparam logic [7:0] st_none     = 8'hf8;
    localparam logic [7:0] status_mask = 8'hf8;
    // reset values, general call address and bits per byte
    localparam logic [7:0] addr_reset  = 8'h00;
    localparam logic [7:0] data_reset  = 8'hff;
    localparam logic [6:0] gc_addr     = 7'h00;
    localparam logic [3:0] byte_bits   = 4'h8;
    typedef enum logic [3:0] {
        s_idle  = 4'b0001,
        s_shift = 4'b0010,
        s_ack   = 4'b0100,
        s_hold  = 4'b1000
    } rx_state_t;
endpackage
`default_nettype wire

//--- verilog/twowire_slave_receiver.sv
// Contract
// - respond only when address bits match own_address_field
// - general call address answered only when general_call_enable_bit is one
// - after own or general call address, write bit selects slave receiving
// - own address plus write acknowledged: flag set, status 0x60
// - addressed after lost arbitration: status 0x68 own, 0x78 general call
// - general call acknowledged without arbitration loss: flag set, status 0x70
// - own-addressed data byte acknowledged: flag, status 0x80, byte readable
// - general call data: 0x90 when acknowledged, 0x98 when refused
// - own-addressed data byte refused: flag with distinct status, byte readable
// - after flag clear, next byte acknowledged only if ack enable is one
// - clearing flag after refused byte returns to unaddressed slave state
// - start request at that clear issues START once the bus is free
// - ack enable cleared mid transfer: not-acknowledge after next data byte
// - ack enable zero: own address ignored, bus still monitored
// - in deep sleep, address match wakes core, clock held until flag clear
// - data register not updated by bytes received in deep sleep
//
// Local design decisions: strobed register access and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
module twowire_slave_receiver
    import twowire_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       reset_n,
    input  wire logic [1:0] addr,
    input  wire logic [7:0] wdata,
    input  wire logic       wr,
    input  wire logic       rd,
    output logic      [7:0] rdata,
    input  wire logic       scl_in,
    output logic            scl_out,
    output logic            scl_oe_n,
    input  wire logic       sda_in,
    output logic            sda_out,
    output logic            sda_oe_n,
    input  wire logic       arb_lost,
    input  wire logic       deep_sleep,
    output logic            wake_req,
    output logic            start_issue
);
    // pin synchronisers; the third stage only serves edge detection
    logic scl_m, scl_s, scl_q;
    logic sda_m, sda_s, sda_q;

    always_ff @(posedge clk)
    begin
        if (!reset_n)
        begin
            scl_m <= 1'b1;
            scl_s <= 1'b1;
            scl_q <= 1'b1;
            sda_m <= 1'b1;
            sda_s <= 1'b1;
            sda_q <= 1'b1;
        end
        else
        begin
            scl_m <= scl_in;
            scl_s <= scl_m;
            scl_q <= scl_s;
            sda_m <= sda_in;
            sda_s <= sda_m;
            sda_q <= sda_s;
        end
    end

    // bus events seen on the synchronised lines
    logic scl_rise, scl_fall, start_det, stop_det;
    assign scl_rise  = scl_s & ~scl_q;
    assign scl_fall  = ~scl_s & scl_q;
    assign start_det = scl_s & scl_q & sda_q & ~sda_s;
    assign stop_det  = scl_s & scl_q & ~sda_q & sda_s;

    rx_state_t  state, next_state;
    logic [7:0] shreg, next_shreg;
    logic [3:0] cnt, next_cnt;
    logic       is_addr, next_is_addr;
    logic       addressed, next_addressed;
    logic       gc_mode, next_gc_mode;
    logic       arb_mode, next_arb_mode;
    logic       ack_given, next_ack_given;
    logic       drive_sda, next_drive_sda;
    logic       hold_scl, next_hold_scl;
    logic       flag, next_flag;
    logic       ack_en, next_ack_en;
    logic       start_req, next_start_req;
    logic       enable, next_enable;
    logic [7:0] status, next_status;
    logic [7:0] data_reg, next_data_reg;
    logic [7:0] addr_reg, next_addr_reg;
    logic       bus_busy, next_bus_busy;
    logic       start_pend, next_start_pend;
    logic       next_start_issue;
    logic       next_wake_req;
    logic [7:0] next_rdata;
    logic       own_hit, gc_hit, flag_clr, set_flag;
    logic [7:0] set_code;

    // address compare on the assembled byte
    assign own_hit = (shreg[7:1] == addr_reg[7:1]);
    assign gc_hit  = (shreg[7:1] == gc_addr) & addr_reg[gce_pos];
    // writing one to the flag bit clears it
    assign flag_clr = wr & (addr == ctrl_off) & wdata[flag_pos];

    // receive sequencer, register writes and read mux
    always_comb
    begin
        next_state      = state;
        next_shreg      = shreg;
        next_cnt        = cnt;
        next_is_addr    = is_addr;
        next_addressed  = addressed;
        next_gc_mode    = gc_mode;
        next_arb_mode   = arb_mode;
        next_ack_given  = ack_given;
        next_drive_sda  = drive_sda;
        next_ack_en     = ack_en;
        next_start_req  = start_req;
        next_enable     = enable;
        next_status     = status;
        next_data_reg   = data_reg;
        next_addr_reg   = addr_reg;
        next_bus_busy   = bus_busy;
        next_start_pend = start_pend;
        next_wake_req   = wake_req;
        next_rdata      = 8'h00;
        set_flag        = 1'b0;
        set_code        = status;

        // software writes; stop request is not stored at all
        if (wr && addr == ctrl_off)
        begin
            next_ack_en    = wdata[ack_en_pos];
            next_start_req = wdata[start_pos];
            next_enable    = wdata[enable_pos];
        end
        else if (wr && addr == data_off)
        begin
            next_data_reg = wdata;
        end
        else if (wr && addr == addr_off)
        begin
            next_addr_reg = wdata;
        end

        // bus occupancy, kept even while disabled
        if (start_det)
        begin
            next_bus_busy = 1'b1;
        end
        else if (stop_det)
        begin
            next_bus_busy = 1'b0;
        end

        if (!enable)
        begin
            next_state     = s_idle;
            next_addressed = 1'b0;
            next_drive_sda = 1'b0;
        end
        else if (start_det || stop_det)
        begin
            // stop or repeated start ends an addressed transfer
            if (addressed)
            begin
                set_flag = 1'b1;
                set_code = st_stop;
            end
            next_addressed = 1'b0;
            next_drive_sda = 1'b0;
            next_state     = start_det ? s_shift : s_idle;
            next_is_addr   = 1'b1;
            next_cnt       = 4'h0;
        end
        else
        begin
            case (state)
                s_shift:
                begin
                    if (scl_rise)
                    begin
                        next_shreg = {shreg[6:0], sda_s};
                        next_cnt   = cnt + 4'h1;
                    end
                    else if (scl_fall && cnt == byte_bits)
                    begin
                        next_cnt = 4'h0;
                        if (is_addr)
                        begin
                            // own address wins over the general call
                            if ((own_hit || gc_hit) && !shreg[0] && ack_en)
                            begin
                                next_state     = s_ack;
                                next_drive_sda = 1'b1;
                                next_ack_given = 1'b1;
                                next_addressed = 1'b1;
                                next_gc_mode   = ~own_hit;
                                next_arb_mode  = arb_lost;
                            end
                            else
                            begin
                                // read direction belongs to the transmitter side
                                next_state = s_idle;
                            end
                        end
                        else
                        begin
                            next_state     = s_ack;
                            next_drive_sda = ack_en;
                            next_ack_given = ack_en;
                            if (!deep_sleep)
                            begin
                                next_data_reg = shreg;
                            end
                        end
                    end
                end
                s_ack:
                begin
                    if (scl_fall)
                    begin
                        next_drive_sda = 1'b0;
                        next_state     = s_hold;
                        set_flag       = 1'b1;
                        next_is_addr   = 1'b0;
                        if (is_addr)
                        begin
                            if (gc_mode)
                            begin
                                set_code = arb_mode ? st_arb_gc : st_gc;
                            end
                            else
                            begin
                                set_code = arb_mode ? st_arb_own : st_own_w;
                            end
                            next_wake_req = deep_sleep;
                        end
                        else if (gc_mode)
                        begin
                            set_code = ack_given ? st_gc_data : st_gc_nack;
                        end
                        else
                        begin
                            set_code = ack_given ? st_own_data : st_own_nack;
                        end
                    end
                end
                s_hold:
                begin
                    if (!flag)
                    begin
                        next_cnt = 4'h0;
                        if (ack_given)
                        begin
                            next_state = s_shift;
                        end
                        else
                        begin
                            next_state     = s_idle;
                            next_addressed = 1'b0;
                            next_start_pend = start_req;
                        end
                    end
                end
                default:
                begin
                    next_state = s_idle;
                end
            endcase
        end

        // a hardware set wins over a software clear in the same cycle
        next_flag = set_flag | (flag & ~flag_clr);
        if (set_flag)
        begin
            next_status = set_code;
        end
        else if (flag_clr)
        begin
            next_status = st_none;
        end
        if (!next_flag)
        begin
            next_wake_req = 1'b0;
        end
        // stretch only while parked waiting on software
        next_hold_scl = (next_state == s_hold) & next_flag;

        // queued start goes out once the bus is seen free
        next_start_issue = start_pend & ~bus_busy;
        if (next_start_issue)
        begin
            next_start_pend = 1'b0;
            next_start_req  = 1'b0;
        end

        // read data stands one cycle after the strobe
        if (rd && addr == ctrl_off)
        begin
            next_rdata = 8'h00;
            next_rdata[flag_pos]   = flag;
            next_rdata[ack_en_pos] = ack_en;
            next_rdata[start_pos]  = start_req;
            next_rdata[enable_pos] = enable;
        end
        else if (rd && addr == status_off)
        begin
            next_rdata = status & status_mask;
        end
        else if (rd && addr == data_off)
        begin
            next_rdata = data_reg;
        end
        else if (rd && addr == addr_off)
        begin
            next_rdata = addr_reg;
        end
    end

    always_ff @(posedge clk)
    begin
        if (!reset_n)
        begin
            state       <= s_idle;
            shreg       <= 8'h00;
            cnt         <= 4'h0;
            is_addr     <= 1'b1;
            addressed   <= 1'b0;
            gc_mode     <= 1'b0;
            arb_mode    <= 1'b0;
            ack_given   <= 1'b0;
            drive_sda   <= 1'b0;
            hold_scl    <= 1'b0;
            flag        <= 1'b0;
            ack_en      <= 1'b0;
            start_req   <= 1'b0;
            enable      <= 1'b0;
            status      <= st_none;
            data_reg    <= data_reset;
            addr_reg    <= addr_reset;
            bus_busy    <= 1'b0;
            start_pend  <= 1'b0;
            start_issue <= 1'b0;
            wake_req    <= 1'b0;
            rdata       <= 8'h00;
        end
        else
        begin
            state       <= next_state;
            shreg       <= next_shreg;
            cnt         <= next_cnt;
            is_addr     <= next_is_addr;
            addressed   <= next_addressed;
            gc_mode     <= next_gc_mode;
            arb_mode    <= next_arb_mode;
            ack_given   <= next_ack_given;
            drive_sda   <= next_drive_sda;
            hold_scl    <= next_hold_scl;
            flag        <= next_flag;
            ack_en      <= next_ack_en;
            start_req   <= next_start_req;
            enable      <= next_enable;
            status      <= next_status;
            data_reg    <= next_data_reg;
            addr_reg    <= next_addr_reg;
            bus_busy    <= next_bus_busy;
            start_pend  <= next_start_pend;
            start_issue <= next_start_issue;
            wake_req    <= next_wake_req;
            rdata       <= next_rdata;
        end
    end

    // open-drain pins: level is always low, enables are active low
    assign scl_out  = 1'b0;
    assign sda_out  = 1'b0;
    assign scl_oe_n = ~hold_scl;
    assign sda_oe_n = ~drive_sda;

endmodule // twowire_slave_receiver
`default_nettype wire

//--- verif/twowire_monitor.sv
`timescale 1ns/10ps
`default_nettype none
module twowire_monitor
    import twowire_pkg::*;
(
    input wire logic       clk,
    input wire logic       reset_n,
    input wire logic [1:0] addr,
    input wire logic [7:0] wdata,
    input wire logic       wr,
    input wire logic       rd,
    input wire logic [7:0] rdata,
    input wire logic       scl_in,
    input wire logic       scl_out,
    input wire logic       scl_oe_n,
    input wire logic       sda_in,
    input wire logic       sda_out,
    input wire logic       sda_oe_n,
    input wire logic       arb_lost,
    input wire logic       deep_sleep,
    input wire logic       wake_req,
    input wire logic       start_issue
);
    default clocking @(posedge clk);
    endclocking
    default disable iff (!reset_n);
    // software writes one to the flag while the bus is held
    sequence flag_clear;
        wr && addr == ctrl_off && wdata[flag_pos];
    endsequence
    sequence held_clear;
        flag_clear ##0 !scl_oe_n;
    endsequence
    sequence status_read;
        $past(rd) && $past(addr) == status_off;
    endsequence
    // the hold must end promptly, or the master hangs forever
    AST_STRETCH_END: assert property (held_clear |-> ##[1:2] scl_oe_n)
        else $error("bus clock still held after flag clear");
    AST_WAKE_END: assert property (flag_clear ##0 wake_req |-> ##[1:2] !wake_req)
        else $error("wake request outlived flag clear");
    AST_WAKE_CAUSE: assert property ($rose(wake_req) |-> $past(deep_sleep))
        else $error("wake request outside deep sleep");
    AST_ACK_IN_LOW: assert property ($fell(sda_oe_n) |-> !scl_in)
        else $error("acknowledge driven while bus clock high");
    AST_ACK_HOLD: assert property (!sda_oe_n && scl_in |=> !sda_oe_n)
        else $error("acknowledge dropped while bus clock high");
    AST_STRETCH_LOW: assert property ($fell(scl_oe_n) |-> !scl_in)
        else $error("stretch began with bus clock high");
    AST_PRESCALE_ZERO: assert property (status_read |-> rdata[2:0] == 3'h0)
        else $error("status low bits not zero");
    AST_STOP_BIT_READ: assert property ($past(rd) && $past(addr) == ctrl_off |-> !rdata[4])
        else $error("stop request bit reads as set");
    AST_START_ONE: assert property (start_issue |=> !start_issue)
        else $error("start pulse longer than one cycle");
    AST_RDATA_IDLE: assert property (!$past(rd) |-> rdata == 8'h00)
        else $error("read data outside its cycle");
    AST_DRIVE_LOW: assert property (!sda_oe_n |-> !sda_out && scl_oe_n)
        else $error("data line driven high or together with a clock stretch");
endmodule // twowire_monitor
bind twowire_slave_receiver twowire_monitor mon (
    .clk(clk), .reset_n(reset_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .scl_in(scl_in), .scl_out(scl_out), .scl_oe_n(scl_oe_n),
    .sda_in(sda_in), .sda_out(sda_out), .sda_oe_n(sda_oe_n), .arb_lost(arb_lost),
    .deep_sleep(deep_sleep), .wake_req(wake_req), .start_issue(start_issue));
`default_nettype wire

//--- verif/bus_master_model.sv
`timescale 1ns/10ps
`default_nettype none
// bus master transmitter; releases lines to one, the wired-and pulls up
module bus_master_model
(
    input  wire logic clk,
    input  wire logic scl,
    input  wire logic sda,
    output logic      scl_m,
    output logic      sda_m,
    output logic      stalled
);
    initial
    begin
        scl_m = 1'b1;
        sda_m = 1'b1;
        stalled = 1'b0;
    end
    // 40 ns, a third of the 120 ns bus clock
    task automatic qtr();
        repeat (10) @(posedge clk);
    endtask
    // one bit; a stretched clock is waited out, but only so long
    task automatic bit_io(input logic b, output logic s);
        int n;
        sda_m <= b;
        qtr();
        scl_m <= 1'b1;
        n = 0;
        while (!scl && n < 4000)
        begin
            @(posedge clk);
            n++;
        end
        if (n >= 4000)
            stalled = 1'b1;
        qtr();
        s = sda;
        scl_m <= 1'b0;
        qtr();
    endtask
    // eight bits msb first, then the acknowledge slot
    task automatic xfer(input logic [7:0] d, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--)
            bit_io(d[i], s);
        bit_io(1'b1, s);
        ack = !s;
    endtask
    task automatic start();
        sda_m <= 1'b0;
        qtr();
        scl_m <= 1'b0;
        qtr();
    endtask
    task automatic stop();
        sda_m <= 1'b0;
        qtr();
        scl_m <= 1'b1;
        qtr();
        sda_m <= 1'b1;
        qtr();
    endtask
endmodule // bus_master_model
`default_nettype wire

//--- verif/tb.sv
`timescale 1ns/10ps
`default_nettype none
module tb;
    import twowire_pkg::*;
    logic       clk = 1'b0;
    logic       reset_n = 1'b0;
    logic [1:0] addr = 2'h0;
    logic [7:0] wdata = 8'h00;
    logic       wr = 1'b0;
    logic       rd = 1'b0;
    logic       rd_q = 1'b0;
    logic       arb_lost = 1'b0;
    logic       deep_sleep = 1'b0;
    logic [7:0] rdata, n_start = 8'h00, d;
    logic       scl_m, sda_m, stl, so, scl_oe_n, dout, sda_oe_n, wake_req, start_issue;
    logic [6:0] own;
    logic       ack;
    logic [7:0] expq[$];
    logic [7:0] bad[3];
    int         err_total = 0;
    int         checks_done = 0;
    // open drain lines with pull-ups
    wire  logic scl = scl_m & scl_oe_n;
    wire  logic sda = sda_m & sda_oe_n;
    always #2 clk = ~clk;
    twowire_slave_receiver dut (.clk(clk), .reset_n(reset_n), .addr(addr), .wdata(wdata),
        .wr(wr), .rd(rd), .rdata(rdata), .scl_in(scl), .scl_out(so), .scl_oe_n(scl_oe_n),
        .sda_in(sda), .sda_out(dout), .sda_oe_n(sda_oe_n), .arb_lost(arb_lost),
        .deep_sleep(deep_sleep), .wake_req(wake_req), .start_issue(start_issue));
    bus_master_model m (.clk(clk), .scl(scl), .sda(sda), .scl_m(scl_m), .sda_m(sda_m),
        .stalled(stl));
    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
        checks_done++;
        if (s !== e)
        begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic results();
        $display("checks %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    // read answers come one cycle after the strobe; oldest note first
    always @(posedge clk)
    begin
        rd_q <= rd;
        if (start_issue)
            n_start <= n_start + 8'h01;
        if (rd_q)
            chk("rdata", expq.size() > 0 ? expq.pop_front() : 8'hxx, rdata); // read back
    end
    // a cycle gap after each strobe keeps drivers from clashing
    task automatic wr_reg(input logic [1:0] a, input logic [7:0] v);
        addr <= a;
        wdata <= v;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rd_reg(input logic [1:0] a, input logic [7:0] e);
        expq.push_back(e);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        @(posedge clk);
    endtask
    task automatic byte_out(input logic [7:0] v, input logic e);
        m.xfer(v, ack);
        if (stl)
        begin
            err_total++;
            $display("[FAIL] bus clock expected released seen held");
            results();
        end
        chk("ack", {7'h00, e}, {7'h00, ack});
    endtask
    initial
    begin
        void'($urandom(19));
        own = 7'h01 + 7'($urandom_range(0, 125)); // never the general call
        repeat (4) @(posedge clk);
        reset_n <= 1'b1;
        repeat (4) @(posedge clk);
        rd_reg(ctrl_off, 8'h00); // disarmed after reset
        rd_reg(status_off, st_none); // idle code
        rd_reg(data_off, data_reset); // data reset value
        wr_reg(ctrl_off, 8'h57);
        rd_reg(ctrl_off, 8'h44); // stop bit ignored
        wr_reg(addr_off, {own, 1'b1});
        rd_reg(addr_off, {own, 1'b1}); // gce set
        $display("test registers done");
        for (int k = 0; k < 4; k++)
        begin
            d = 8'($urandom);
            arb_lost <= k[0];
            m.start();
            byte_out(k[1] ? 8'h00 : {own, 1'b0}, 1'b1); // address acked
            rd_reg(status_off, k[1] ? (k[0] ? st_arb_gc : st_gc)
                : (k[0] ? st_arb_own : st_own_w)); // address codes
            arb_lost <= 1'b0;
            wr_reg(ctrl_off, 8'hc4);
            byte_out(d, 1'b1); // next byte acked
            rd_reg(status_off, k[1] ? st_gc_data : st_own_data); // data code
            rd_reg(data_off, d); // byte readable
            wr_reg(ctrl_off, 8'h84);
            byte_out(~d, 1'b0); // refused byte
            rd_reg(status_off, k[1] ? st_gc_nack : st_own_nack); // nack code
            rd_reg(data_off, ~d); // byte kept
            wr_reg(ctrl_off, 8'hc4);
            m.stop();
        end
        $display("test addressing done");
        m.start();
        byte_out({own, 1'b0}, 1'b1); // addressed again
        wr_reg(ctrl_off, 8'h84);
        byte_out(8'h5a, 1'b0); // refused with ack enable off
        wr_reg(ctrl_off, 8'ha4);
        byte_out({own, 1'b0}, 1'b0); // unaddressed, no recognition
        chk("starts", 8'h00, n_start); // bus still busy
        m.stop();
        for (int i = 0; i < 100 && n_start == 8'h00; i++)
            @(posedge clk);
        chk("starts", 8'h01, n_start); // start once bus free
        $display("test restart done");
        wr_reg(addr_off, {own, 1'b0});
        wr_reg(ctrl_off, 8'h04);
        m.start();
        byte_out({own, 1'b0}, 1'b0); // ack enable off, own address ignored
        m.stop();
        wr_reg(ctrl_off, 8'h44); // armed for reception
        bad = '{{~own, 1'b0}, {own, 1'b1}, 8'h00};
        foreach (bad[i])
        begin
            m.start();
            byte_out(bad[i], 1'b0); // refused addresses
            m.stop();
        end
        rd_reg(status_off, st_none); // no flag raised
        $display("test refusals done");
        deep_sleep <= 1'b1;
        m.start();
        byte_out({own, 1'b0}, 1'b1); // match in sleep
        chk("wake", 8'h01, {7'h00, wake_req}); // core woken
        chk("hold", 8'h00, {7'h00, scl_oe_n}); // bus clock held low
        rd_reg(status_off, st_own_w); // address code in sleep
        wr_reg(ctrl_off, 8'hc4);
        chk("wake", 8'h00, {7'h00, wake_req}); // ends with flag
        chk("hold", 8'h01, {7'h00, scl_oe_n}); // clock released with flag
        byte_out(8'h3c, 1'b1); // reception after wake
        rd_reg(data_off, 8'h5a); // sleep byte not stored
        deep_sleep <= 1'b0;
        wr_reg(ctrl_off, 8'hc4);
        m.stop();
        $display("test sleep done");
        results();
    end
endmodule // tb
`default_nettype wire
